/* File: rtl/lrg_consts.svh */
// Purpose: Offsets, field positions, reset values and wait counts for the
//   receiver output gating block.
// Assumes: Included by bare name; definitions only.
// Notes: Summary of operation follows.
// Summary of operation
// - Register 0x1e bits 4..0 disable even-port channels A..E; 1 disables, default 0.
// - Register 0x1f bits 4..0 disable odd-port channels A..E; 1 disables, default 0.
// - Availability field 11: outputs live whenever clock present, lock ignored.
// - Field 10: outputs live after 1K cycles and strobes aligned within half interval.
// - Field 01: outputs live only after 2K input clock cycles.
// - Field 00, the default: outputs live after 1K input clock cycles.
// - Register 0x1f bit 5 selects wait counter size, 0 gives 1K except in field 01, 1 gives 2K.
`ifndef LRG_CONSTS_SVH
`define LRG_CONSTS_SVH

`define LRG_ADDR_EVEN 8'h1e
`define LRG_ADDR_ODD 8'h1f
`define LRG_RST_EVEN 8'h00
`define LRG_RST_ODD 8'h00
`define LRG_DIS_HI 4
`define LRG_DIS_MASK 8'h1f
`define LRG_MODE_HI 7
`define LRG_MODE_LO 6
`define LRG_WAIT_SIZE_BIT 5
`define LRG_WAIT_SHORT 1024
`define LRG_WAIT_LONG 2048
`define LRG_RDATA_IDLE 8'h00

`endif

/* File: rtl/lrg_pkg.sv */
// Purpose: Types shared by the output gating block.
// Assumes: Constants live in lrg_consts.svh.
// Notes: Availability codes are the field values of register 0x1f [7:6].
package lrg_pkg;

  typedef enum logic [1:0] {
    AVAIL_1K = 2'h0,
    AVAIL_2K = 2'h1,
    AVAIL_ALIGN = 2'h2,
    AVAIL_FORCE = 2'h3
  } lrg_avail_t;

  typedef enum logic [3:0] {
    ST_IDLE = 4'h1,
    ST_COUNT = 4'h2,
    ST_ALIGN = 4'h4,
    ST_LIVE = 4'h8
  } lrg_state_t;

  typedef struct packed {
    logic wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } lrg_reg_req_t;

endpackage

/* File: rtl/lrg_chan_gate.sv */
// Purpose: One output channel: registers data, forces zero while gated off.
// Assumes: Data arrives on the same clock; no synchroniser needed.
// Notes: Zero is the inactive level of a gated channel.
`timescale 1ns/1ps
module lrg_chan_gate #(
  parameter int W = 10
) (
  input wire logic clk_in,          // Pixel clock
  input wire logic reset_in,        // Sync reset, active high
  input wire logic ce_in,           // Clock enable
  input wire logic en_in,           // Channel may drive
  input wire logic [W-1:0] din_in,  // Deserialised channel data
  output logic [W-1:0] dout_out     // Gated registered data
);

  wire [W-1:0] next_dout;

  assign next_dout = en_in ? din_in : '0;

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      dout_out <= '0;
    end else if (ce_in) begin
      dout_out <= next_dout;
    end
  end

endmodule

/* File: rtl/lrg_top.sv */
// Purpose: Register bank gating the even and odd parallel output channels and
//   deciding when outputs become available after the link clock appears.
// Assumes: CLK_IN is the recovered pixel clock; clock-present and strobe
//   alignment arrive from analog logic and are synchronised here.
// Notes: Channel slice i of a data vector pairs with disable bit i (A = 4).
`timescale 1ns/1ps
`include "lrg_consts.svh"
module lrg_top #(
  parameter int CH_W = 10,
  parameter int WAIT_SHORT = `LRG_WAIT_SHORT,
  parameter int WAIT_LONG = `LRG_WAIT_LONG
) (
  input wire logic CLK_IN,                          // Pixel clock, 20 MHz
  input wire logic RESET_IN,                        // Sync reset, active high
  input wire logic CE_IN,                           // Freezes all state when low
  input wire lrg_pkg::lrg_reg_req_t REG_REQ_IN,     // Register write/address
  output logic [7:0] REG_RDATA_OUT,                 // Registered read data
  input wire logic CLK_PRESENT_IN,                  // Clock-present indication
  input wire logic STROBE_ALIGNED_IN,               // Strobes within half interval
  input wire logic [5*CH_W-1:0] EVEN_DATA_IN,       // Even channels E..A low to high
  input wire logic [5*CH_W-1:0] ODD_DATA_IN,        // Odd channels E..A low to high
  output logic [5*CH_W-1:0] EVEN_DATA_OUT,          // Gated even_pixel_outputs
  output logic [5*CH_W-1:0] ODD_DATA_OUT,           // Gated odd_pixel_outputs
  output logic [4:0] EVEN_EN_OUT,                   // Even channels driving
  output logic [4:0] ODD_EN_OUT,                    // Odd channels driving
  output logic OUTPUTS_VALID_OUT                    // Availability condition met
);

  localparam logic [11:0] SHORT_LAST = 12'(WAIT_SHORT - 1);
  localparam logic [11:0] LONG_LAST = 12'(WAIT_LONG - 1);

  logic [7:0] even_dis;
  logic [7:0] odd_reg;
  logic present_meta;
  logic present_s;
  logic aligned_meta;
  logic aligned_s;
  logic [11:0] cnt;
  lrg_pkg::lrg_state_t st;
  lrg_pkg::lrg_state_t next_st;

  wire wr_even;
  wire wr_odd;
  wire [7:0] next_rdata;
  wire [1:0] mode_bits;
  wire wait_long;
  wire use_long;
  wire [11:0] cnt_last;
  wire count_done;
  wire live;
  wire [11:0] next_cnt;
  wire [9:0] chan_en;

  // Register decode
  assign wr_even = REG_REQ_IN.wr && (REG_REQ_IN.addr == `LRG_ADDR_EVEN);
  assign wr_odd = REG_REQ_IN.wr && (REG_REQ_IN.addr == `LRG_ADDR_ODD);
  assign next_rdata = (REG_REQ_IN.addr == `LRG_ADDR_EVEN) ? even_dis :
                      (REG_REQ_IN.addr == `LRG_ADDR_ODD) ? odd_reg : `LRG_RDATA_IDLE;

  always_ff @(posedge CLK_IN) begin
    if (RESET_IN) begin
      even_dis <= `LRG_RST_EVEN;
      odd_reg <= `LRG_RST_ODD;
      REG_RDATA_OUT <= `LRG_RDATA_IDLE;
    end else if (CE_IN) begin
      if (wr_even) begin
        even_dis <= REG_REQ_IN.wdata & `LRG_DIS_MASK;
      end
      if (wr_odd) begin
        odd_reg <= REG_REQ_IN.wdata;
      end
      REG_RDATA_OUT <= next_rdata;
    end
  end

  // Pin inputs from the analog side: two flops before use
  always_ff @(posedge CLK_IN) begin
    if (RESET_IN) begin
      present_meta <= 1'b0;
      present_s <= 1'b0;
      aligned_meta <= 1'b0;
      aligned_s <= 1'b0;
    end else if (CE_IN) begin
      present_meta <= CLK_PRESENT_IN;
      present_s <= present_meta;
      aligned_meta <= STROBE_ALIGNED_IN;
      aligned_s <= aligned_meta;
    end
  end

  assign mode_bits = odd_reg[`LRG_MODE_HI:`LRG_MODE_LO];
  assign wait_long = odd_reg[`LRG_WAIT_SIZE_BIT];
  assign use_long = wait_long || (mode_bits == lrg_pkg::AVAIL_2K);
  assign cnt_last = use_long ? LONG_LAST : SHORT_LAST;
  assign count_done = (cnt == cnt_last);
  assign live = (st == lrg_pkg::ST_LIVE);

  always_comb begin
    next_st = st;
    if (!present_s) begin
      next_st = lrg_pkg::ST_IDLE;
    end else if (mode_bits == lrg_pkg::AVAIL_FORCE) begin
      next_st = lrg_pkg::ST_LIVE;
    end else begin
      unique case (st)
        lrg_pkg::ST_IDLE: begin
          next_st = lrg_pkg::ST_COUNT;
        end
        lrg_pkg::ST_COUNT: begin
          if (count_done) begin
            next_st = (mode_bits == lrg_pkg::AVAIL_ALIGN) ? lrg_pkg::ST_ALIGN :
                                                             lrg_pkg::ST_LIVE;
          end
        end
        lrg_pkg::ST_ALIGN: begin
          if (aligned_s || (mode_bits != lrg_pkg::AVAIL_ALIGN)) begin
            next_st = lrg_pkg::ST_LIVE;
          end
        end
        lrg_pkg::ST_LIVE: begin
          next_st = lrg_pkg::ST_LIVE;
        end
        default: begin
          next_st = lrg_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // counter restarts on loss
  // Cleared in the very edge that sees the clock gone, not one later
  assign next_cnt = (st == lrg_pkg::ST_COUNT && present_s) ? 12'(cnt + 12'h001) : 12'h000;

  always_ff @(posedge CLK_IN) begin
    if (RESET_IN) begin
      st <= lrg_pkg::ST_IDLE;
      cnt <= 12'h000;
    end else if (CE_IN) begin
      st <= next_st;
      cnt <= next_cnt;
    end
  end

  assign chan_en = {~odd_reg[`LRG_DIS_HI:0], ~even_dis[`LRG_DIS_HI:0]} & {10{live}};
  assign EVEN_EN_OUT = chan_en[4:0];
  assign ODD_EN_OUT = chan_en[9:5];
  assign OUTPUTS_VALID_OUT = live;

  // Per-channel gating, slices 0..4 even and 5..9 odd
  genvar gi;
  generate
    for (gi = 0; gi < 10; gi++) begin : g_gate
      if (gi < 5) begin : g_even
        lrg_chan_gate #(.W(CH_W)) lrg_chan_gate_inst (
          .clk_in(CLK_IN),
          .reset_in(RESET_IN),
          .ce_in(CE_IN),
          .en_in(chan_en[gi]),
          .din_in(EVEN_DATA_IN[gi*CH_W +: CH_W]),
          .dout_out(EVEN_DATA_OUT[gi*CH_W +: CH_W])
        );
      end else begin : g_odd
        lrg_chan_gate #(.W(CH_W)) lrg_chan_gate_inst (
          .clk_in(CLK_IN),
          .reset_in(RESET_IN),
          .ce_in(CE_IN),
          .en_in(chan_en[gi]),
          .din_in(ODD_DATA_IN[(gi-5)*CH_W +: CH_W]),
          .dout_out(ODD_DATA_OUT[(gi-5)*CH_W +: CH_W])
        );
      end
    end
  endgenerate

  // Helper: enabled cycles since clock-present was last seen low, saturating
  logic [12:0] run_cnt;
  always_ff @(posedge CLK_IN) begin
    if (RESET_IN) begin
      run_cnt <= 13'h0000;
    end else if (CE_IN) begin
      if (!present_s) begin
        run_cnt <= 13'h0000;
      end else if (run_cnt != 13'h1fff) begin
        run_cnt <= run_cnt + 13'h0001;
      end
    end
  end

  default clocking cb @(posedge CLK_IN); endclocking
  default disable iff (RESET_IN);

  chk_even_disable_gate: assert property (
    CE_IN && even_dis[0] |-> !EVEN_EN_OUT[0] ##1 EVEN_DATA_OUT[CH_W-1:0] == '0)
    else $error("Disabled even channel still drives");
  chk_odd_disable_gate: assert property (
    CE_IN && odd_reg[4] |-> !ODD_EN_OUT[4] ##1 ODD_DATA_OUT[5*CH_W-1 -: CH_W] == '0)
    else $error("Disabled odd channel still drives");
  chk_force_mode_live: assert property (
    CE_IN && present_s && mode_bits == 2'h3 |=> OUTPUTS_VALID_OUT)
    else $error("Force mode did not go live with clock present");
  chk_align_holds_off: assert property (
    CE_IN && st == lrg_pkg::ST_ALIGN && present_s && !aligned_s && mode_bits == 2'h2
    |=> !OUTPUTS_VALID_OUT)
    else $error("Went live before strobe alignment");
  chk_long_wait_min: assert property (
    $rose(OUTPUTS_VALID_OUT) && mode_bits == 2'h1 |-> run_cnt > 13'(WAIT_LONG))
    else $error("Outputs live before long wait elapsed");
  chk_short_wait_exact: assert property (
    $rose(OUTPUTS_VALID_OUT) && mode_bits == 2'h0 && !wait_long
    |-> run_cnt == 13'(WAIT_SHORT + 1))
    else $error("Default wait not one short count");
  chk_size_select_long: assert property (
    $rose(OUTPUTS_VALID_OUT) && mode_bits == 2'h0 && wait_long
    |-> run_cnt > 13'(WAIT_LONG))
    else $error("Size bit did not lengthen wait");
  chk_loss_restart: assert property (
    CE_IN && !present_s |=> !OUTPUTS_VALID_OUT && cnt == 12'h000 && EVEN_EN_OUT == 5'h00)
    else $error("Clock loss did not restart availability");
  chk_reg_reset_zero: assert property (
    $past(RESET_IN) |-> even_dis == 8'h00 && odd_reg == 8'h00 && !OUTPUTS_VALID_OUT)
    else $error("Registers not at default after reset");

  cov_align_live: cover property (
    st == lrg_pkg::ST_ALIGN && mode_bits == 2'h2 ##1 OUTPUTS_VALID_OUT);
  cov_force_live: cover property (mode_bits == 2'h3 && $rose(OUTPUTS_VALID_OUT));
  cov_channel_off: cover property (OUTPUTS_VALID_OUT && EVEN_EN_OUT != 5'h1f);
  cov_clock_loss: cover property (OUTPUTS_VALID_OUT ##1 !present_s);

endmodule

/* File: sim/lrg_tcon_model.sv */
// Purpose: Panel timing controller latching the gated parallel video.
// Assumes: Samples on the pixel clock rising edge.
// Notes: A disabled channel floats, so it shows a toggling pattern.
`timescale 1ns/1ps
module lrg_tcon_model #(
  parameter int W = 10
) (
  input wire logic clk_in,           // Pixel clock
  input wire logic valid_in,         // Receiver outputs available
  input wire logic [4:0] en_in,      // Channels driving
  input wire logic [5*W-1:0] data_in, // Parallel pixel data
  output logic [5*W-1:0] seen_out    // Last word taken per enabled channel; disabled channels toggle
);
  always_ff @(posedge clk_in) begin
    for (int i = 0; i < 5; i++) begin
      if (!en_in[i]) begin
        seen_out[i*W +: W] <= ~seen_out[i*W +: W];
      end else if (valid_in) begin
        seen_out[i*W +: W] <= data_in[i*W +: W];
      end
    end
  end
endmodule

/* File: sim/lvds_rx_output_gating_ctrl_tb.sv */
// Purpose: Self-checking bench for the output gating register bank.
// Assumes: Short wait counts of 8 and 16 stand in for 1K and 2K.
// Notes: Wait checks accept windows of three to five counts for synchroniser slack.
`timescale 1ns/1ps
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin errors++; \
  $display("[FAIL] %0t got %h exp %h", $time, (a), (b)); end end
module lvds_rx_output_gating_ctrl_tb;
  localparam int W = 10;
  localparam int WS = 8;
  localparam int WL = 16;
  logic clk = 0, rst = 1, ce = 1, pres = 0, algn = 0, vld;
  lrg_pkg::lrg_reg_req_t req = '0;
  logic [5*W-1:0] ed = 50'h3_5a5a_5a5a_5a5a, od = 50'h1_2345_6789_abcd;
  logic [5*W-1:0] eo, oo, es;
  logic [7:0] rd;
  logic [4:0] een, oen;
  int errors = 0, n_tests = 0, n;
  initial begin
    forever #25 clk = ~clk;
  end
  lrg_top #(.CH_W(W), .WAIT_SHORT(WS), .WAIT_LONG(WL)) lrg_top_inst (
    .CLK_IN(clk), .RESET_IN(rst), .CE_IN(ce), .REG_REQ_IN(req), .REG_RDATA_OUT(rd),
    .CLK_PRESENT_IN(pres), .STROBE_ALIGNED_IN(algn), .EVEN_DATA_IN(ed),
    .ODD_DATA_IN(od), .EVEN_DATA_OUT(eo), .ODD_DATA_OUT(oo), .EVEN_EN_OUT(een),
    .ODD_EN_OUT(oen), .OUTPUTS_VALID_OUT(vld));
  lrg_tcon_model #(.W(W)) lrg_tcon_model_inst (
    .clk_in(clk), .valid_in(vld), .en_in(een), .data_in(eo), .seen_out(es));
  function automatic logic [5*W-1:0] msk(input logic [4:0] dis);
    for (int i = 0; i < 5; i++) msk[i*W +: W] = {W{~dis[i]}};
  endfunction
  task automatic cyc(input int k);
    repeat (k) @(negedge clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    req = '{1'b1, a, d};
    cyc(1);
    req = '{1'b0, a, d};
    cyc(1);
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
    req = '{1'b0, a, 8'h00};
    cyc(2);
    `CHK(rd, exp)
  endtask
  task automatic wait_live();
    n = 0;
    while (vld !== 1'b1 && n < 100) begin
      cyc(1);
      n++;
    end
  endtask
  task automatic start(input logic [7:0] cfg);
    pres = 0;
    cyc(4);
    wr(8'h1f, cfg);
    pres = 1;
    wait_live();
  endtask
  task automatic t_regs();
    rdchk(8'h1e, 8'h00);
    rdchk(8'h1f, 8'h00);
    `CHK(een, 5'h00)
    `CHK(eo, 50'h0)
    wr(8'h1e, 8'hff);
    rdchk(8'h1e, 8'h1f);
    wr(8'h1f, 8'hff);
    rdchk(8'h1f, 8'hff);
    wr(8'h20, 8'h55);
    rdchk(8'h20, 8'h00);
    wr(8'h1e, 8'h00);
  endtask
  task automatic t_modes();
    start(8'h00);
    `CHK(n inside {[WS+3:WS+5]}, 1'b1)
    start(8'h20);
    `CHK(n inside {[WL+3:WL+5]}, 1'b1)
    start(8'h40);
    `CHK(n inside {[WL+3:WL+5]}, 1'b1)
    start(8'hc0);
    `CHK(n inside {[2:5]}, 1'b1)
    start(8'h80);
    `CHK(n, 100)
    algn = 1;
    wait_live();
    `CHK(n inside {[1:5]}, 1'b1)
  endtask
  task automatic t_gate();
    wr(8'h1e, 8'h15);
    wr(8'h1f, 8'h0a);
    cyc(2);
    `CHK(een, 5'h0a)
    `CHK(oen, 5'h15)
    `CHK(eo, ed & msk(5'h15))
    `CHK(oo, od & msk(5'h0a))
    `CHK(es & msk(5'h15), ed & msk(5'h15))
    pres = 0;
    cyc(5);
    `CHK(vld, 1'b0)
    `CHK(oen, 5'h00)
    `CHK(oo, 50'h0)
    wr(8'h1f, 8'h00);
    pres = 1;
    cyc(WS);
    pres = 0;
    cyc(4);
    pres = 1;
    wait_live();
    `CHK(n inside {[WS+3:WS+5]}, 1'b1)
  endtask
  // Enable low mid-count: the wait must stretch by the frozen cycles
  task automatic t_ce();
    pres = 0;
    cyc(4);
    pres = 1;
    cyc(5);
    ce = 0;
    cyc(10);
    `CHK(vld, 1'b0)
    ce = 1;
    wait_live();
    `CHK(n inside {[WS-3:WS-1]}, 1'b1)
  endtask
  task automatic wrap_up();
    if (errors == 0 && n_tests > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  initial begin
    cyc(20);
    rst = 0;
    t_regs();
    t_modes();
    t_gate();
    t_ce();
    wrap_up();
  end
  initial begin
    #(3000 * 50);
    errors++;
    wrap_up();
  end
endmodule
